// file: ncs_node_cfg_defs.vh
// Constants for the node configuration and status indicator block
`ifndef NCS_NODE_CFG_DEFS_VH
`define NCS_NODE_CFG_DEFS_VH
// Register byte offsets
`define NCS_OFF_CTRL 8'h00
`define NCS_OFF_CFG 8'h04
`define NCS_OFF_INPUT 8'h08
`define NCS_OFF_LAMP 8'h0C
`define NCS_OFF_IRQ_STAT 8'h10
`define NCS_OFF_IRQ_MASK 8'h14
// Control fields and reset value
`define NCS_CTRL_LAMP_EN 0
`define NCS_CTRL_PAIR_ALLOW 1
`define NCS_CTRL_RESET 2'h3
// Configuration word fields
`define NCS_CFG_RATE_LSB 8
`define NCS_CFG_PAIR 11
`define NCS_CFG_FWUPD 12
`define NCS_CFG_ID_ERR 13
`define NCS_CFG_DONE 14
`define NCS_CFG_KBPS_LSB 16
// Interrupt bits
`define NCS_IRQ_INPUT 0
`define NCS_IRQ_ERROR 1
`define NCS_IRQ_CFG 2
`define NCS_IRQ_RESET 3'h0
// Network management states reported by the protocol core
`define NCS_NMT_OFF 2'h0
`define NCS_NMT_STOPPED 2'h1
`define NCS_NMT_PREOP 2'h2
`define NCS_NMT_OPER 2'h3
// Switch limits
`define NCS_DIGIT_MAX 4'h9
`define NCS_ID_MAX 7'h63
// Indicator timing: one lamp phase in ms, clock in kHz
`define NCS_PHASE_MS 200
`define NCS_CLK_KHZ 100000
`define NCS_PHASE_CYCLES (`NCS_PHASE_MS * `NCS_CLK_KHZ)
`define NCS_PHASES 3'h6
// Cycles let the switch synchroniser fill before the capture
`define NCS_SETTLE_CYCLES 3'h4
// Bus responses
`define NCS_RESP_OKAY 2'h0
`define NCS_RESP_DECERR 2'h3
`endif

// file: ncs_node_cfg.v
// Node configuration decoder and status indicator driver with AXI4-Lite registers
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ncs_node_cfg_defs.vh"
// Functional notes
// - Sixteen sampled inputs form the core input word
// - Node id is tens switch times ten plus units
// - Node ids 1 to 99 allow slave operation
// - Node id zero selects firmware update mode
// - Rate codes 8 to F select pair mode
// - Code pairs map to 10 through 1000 kbit/s
// - Pair mode requests Operational without master command
// - Each ON input switches partner output same index
// - Run lamp shows off, stopped, preop, operational
// - Error lamp shows warning, guarding fail, bus-off
// - Input lamps follow raw level, ignoring polarity
// - Termination lamp lit while termination enabled
module ncs_node_cfg #(
  parameter ADDR_W = 8,
  parameter NCH = 16,
  parameter PHASE_CYCLES = `NCS_PHASE_CYCLES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Front panel switches and input pins
  input wire [3:0] id_tens_sw,
  input wire [3:0] id_units_sw,
  input wire [3:0] rate_sw,
  input wire [NCH-1:0] digital_input_channel,
  input wire term_enable_pin,
  // Protocol core status
  input wire [1:0] core_nmt_state,
  input wire core_err_warn,
  input wire core_guard_fail,
  input wire core_bus_off,
  // Protocol core configuration and data
  output wire [NCH-1:0] input_word,
  output wire [NCH-1:0] pair_out_word,
  output wire [6:0] node_id,
  output wire [2:0] rate_sel,
  output wire pair_mode,
  output wire fw_update_mode,
  output wire slave_enable,
  output wire auto_start_req,
  output wire cfg_done,
  // Lamps and interrupt
  output wire run_lamp,
  output wire err_lamp,
  output wire term_lamp,
  output wire [NCH-1:0] input_lamp,
  output wire irq
);

  // Per-bit filter: take the new level once stages two and three agree
  function [NCH-1:0] agree;
    input [NCH-1:0] s2;
    input [NCH-1:0] s3;
    input [NCH-1:0] held;
    begin
      agree = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
    end
  endfunction

  // Bus rate in kbit/s for a rate code
  function [15:0] rate_kbps;
    input [2:0] code;
    begin
      case (code)
        3'h0: rate_kbps = 16'h000A;
        3'h1: rate_kbps = 16'h0014;
        3'h2: rate_kbps = 16'h0032;
        3'h3: rate_kbps = 16'h007D;
        3'h4: rate_kbps = 16'h00FA;
        3'h5: rate_kbps = 16'h01F4;
        3'h6: rate_kbps = 16'h0320;
        default: rate_kbps = 16'h03E8;
      endcase
    end
  endfunction

  // Pin synchroniser stages, filtered levels and captured configuration
  reg [NCH-1:0] in_s1_reg, in_s2_reg, in_s3_reg, in_filt_reg;
  reg [11:0] sw_s1_reg, sw_s2_reg, sw_s3_reg;
  reg [2:0] term_s_reg, settle_reg, rate_sel_reg, phase_reg;
  reg [6:0] node_id_reg;
  reg term_filt_reg, cfg_done_reg, pair_sw_reg, fw_reg, id_err_reg;
  // Outputs to core and lamps, lamp timing
  reg [NCH-1:0] input_word_reg, pair_out_reg, input_lamp_reg;
  reg pair_mode_reg, slave_en_reg, auto_start_reg;
  reg run_lamp_reg, err_lamp_reg, term_lamp_reg;
  reg [31:0] phase_cnt_reg, wdata_reg, rdata_reg;
  // Registers, interrupts and bus state
  reg [1:0] ctrl_reg, bresp_reg, rresp_reg;
  reg [2:0] irq_stat_reg, irq_mask_reg;
  reg irq_reg, err_any_d_reg, wstrb0_reg, aw_hold_reg, w_hold_reg;
  reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg [ADDR_W-1:0] awaddr_reg;

  // Decoded switch values
  wire [3:0] tens_d = sw_s3_reg[11:8];
  wire [3:0] units_d = sw_s3_reg[7:4];
  wire [6:0] id_calc = {tens_d, 3'h0} + {2'h0, tens_d, 1'b0} + {3'h0, units_d};
  wire digit_bad = (tens_d > `NCS_DIGIT_MAX) || (units_d > `NCS_DIGIT_MAX);
  wire settled = (settle_reg == `NCS_SETTLE_CYCLES);
  wire sw_agree = (sw_s2_reg == sw_s3_reg);
  wire err_any = core_err_warn | core_guard_fail | core_bus_off;
  wire phase_end = (phase_cnt_reg == PHASE_CYCLES - 1);

  // Bus handshake terms
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire ar_take = s_axi_arvalid & arready_reg;
  wire do_wr = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  wire aw_hold_next = (aw_hold_reg & ~do_wr) | aw_take;
  wire w_hold_next = (w_hold_reg & ~do_wr) | w_take;
  wire bvalid_next = do_wr | (bvalid_reg & ~s_axi_bready);
  wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
  wire wr_lane0 = do_wr & wstrb0_reg;
  wire wr_ctrl = wr_lane0 && (awaddr_reg == `NCS_OFF_CTRL);
  wire wr_w1c = wr_lane0 && (awaddr_reg == `NCS_OFF_IRQ_STAT);
  wire wr_mask = wr_lane0 && (awaddr_reg == `NCS_OFF_IRQ_MASK);
  wire wr_known = (awaddr_reg[1:0] == 2'h0) && (awaddr_reg <= `NCS_OFF_IRQ_MASK);

  // Interrupt events raised this cycle
  wire [2:0] irq_evt;
  assign irq_evt[`NCS_IRQ_INPUT] = |(input_word_reg ^ in_filt_reg);
  assign irq_evt[`NCS_IRQ_ERROR] = err_any & ~err_any_d_reg;
  assign irq_evt[`NCS_IRQ_CFG] = settled & ~cfg_done_reg;
  wire [2:0] irq_stat_next = irq_evt
    | (irq_stat_reg & ~(wr_w1c ? wdata_reg[2:0] : 3'h0));

  // Pin synchronisers, three stages with agreement filter
  always @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_reg <= {NCH{1'b0}};
      in_s2_reg <= {NCH{1'b0}};
      in_s3_reg <= {NCH{1'b0}};
      in_filt_reg <= {NCH{1'b0}};
      sw_s1_reg <= 12'h000;
      sw_s2_reg <= 12'h000;
      sw_s3_reg <= 12'h000;
      term_s_reg <= 3'h0;
      term_filt_reg <= 1'b0;
    end else begin
      in_s1_reg <= digital_input_channel;
      in_s2_reg <= in_s1_reg;
      in_s3_reg <= in_s2_reg;
      in_filt_reg <= agree(in_s2_reg, in_s3_reg, in_filt_reg);
      sw_s1_reg <= {id_tens_sw, id_units_sw, rate_sw};
      sw_s2_reg <= sw_s1_reg;
      sw_s3_reg <= sw_s2_reg;
      term_s_reg <= {term_s_reg[1:0], term_enable_pin};
      term_filt_reg <= (term_s_reg[1] == term_s_reg[2]) ? term_s_reg[2] : term_filt_reg;
    end
  end

  // One capture of the switches after reset, held until next reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= 3'h0;
      cfg_done_reg <= 1'b0;
      node_id_reg <= 7'h00;
      rate_sel_reg <= 3'h0;
      pair_sw_reg <= 1'b0;
      fw_reg <= 1'b0;
      id_err_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      if (!settled) begin
        settle_reg <= settle_reg + 3'h1;
      end else if (sw_agree) begin
        cfg_done_reg <= 1'b1;
        node_id_reg <= id_calc;
        rate_sel_reg <= sw_s3_reg[2:0];
        pair_sw_reg <= sw_s3_reg[3];
        fw_reg <= ~digit_bad && (id_calc == 7'h00);
        id_err_reg <= digit_bad || (id_calc > `NCS_ID_MAX);
      end
    end
  end

  // Configuration and data toward the protocol core
  always @(posedge aclk) begin
    if (!aresetn) begin
      input_word_reg <= {NCH{1'b0}};
      pair_out_reg <= {NCH{1'b0}};
      pair_mode_reg <= 1'b0;
      slave_en_reg <= 1'b0;
      auto_start_reg <= 1'b0;
    end else begin
      input_word_reg <= in_filt_reg;
      pair_mode_reg <= cfg_done_reg & pair_sw_reg & ctrl_reg[`NCS_CTRL_PAIR_ALLOW];
      slave_en_reg <= cfg_done_reg & ~fw_reg & ~id_err_reg;
      // Partner mirrors each ON input on the same channel
      pair_out_reg <= pair_mode_reg ? in_filt_reg : {NCH{1'b0}};
      // Ask the core for Operational without waiting for a master
      auto_start_reg <= pair_mode_reg & slave_en_reg
        & (core_nmt_state != `NCS_NMT_OPER);
    end
  end

  // Lamp phase timer: six 200 ms phases per pattern period
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_cnt_reg <= 32'h0;
      phase_reg <= 3'h0;
    end else if (phase_end) begin
      phase_cnt_reg <= 32'h0;
      phase_reg <= (phase_reg == `NCS_PHASES - 3'h1) ? 3'h0 : phase_reg + 3'h1;
    end else begin
      phase_cnt_reg <= phase_cnt_reg + 32'h1;
    end
  end

  // Lamp drivers, all dark in reset or while lamps are disabled
  always @(posedge aclk) begin
    if (!aresetn || !ctrl_reg[`NCS_CTRL_LAMP_EN]) begin
      run_lamp_reg <= 1'b0;
      err_lamp_reg <= 1'b0;
      term_lamp_reg <= 1'b0;
      input_lamp_reg <= {NCH{1'b0}};
    end else begin
      // Single flash on phase 0, blink on even phases
      case (core_nmt_state)
        `NCS_NMT_STOPPED: run_lamp_reg <= (phase_reg == 3'h0);
        `NCS_NMT_PREOP: run_lamp_reg <= ~phase_reg[0];
        `NCS_NMT_OPER: run_lamp_reg <= 1'b1;
        default: run_lamp_reg <= 1'b0;
      endcase
      // Bus-off outranks guarding fail, which outranks warning
      if (core_bus_off) begin
        err_lamp_reg <= 1'b1;
      end else if (core_guard_fail) begin
        err_lamp_reg <= (phase_reg == 3'h0) || (phase_reg == 3'h2);
      end else if (core_err_warn) begin
        err_lamp_reg <= (phase_reg == 3'h0);
      end else begin
        err_lamp_reg <= 1'b0;
      end
      term_lamp_reg <= term_filt_reg;
      input_lamp_reg <= in_filt_reg;
    end
  end

  // Control, mask and sticky interrupt status; a new event beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `NCS_CTRL_RESET;
      irq_mask_reg <= `NCS_IRQ_RESET;
      irq_stat_reg <= `NCS_IRQ_RESET;
      irq_reg <= 1'b0;
      err_any_d_reg <= 1'b0;
    end else begin
      ctrl_reg <= wr_ctrl ? wdata_reg[1:0] : ctrl_reg;
      irq_mask_reg <= wr_mask ? wdata_reg[2:0] : irq_mask_reg;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & (wr_mask ? wdata_reg[2:0] : irq_mask_reg));
      err_any_d_reg <= err_any;
    end
  end

  // AXI4-Lite write channel: address and data in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= {ADDR_W{1'b0}};
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      bresp_reg <= `NCS_RESP_OKAY;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        bresp_reg <= wr_known ? `NCS_RESP_OKAY : `NCS_RESP_DECERR;
      end
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      bvalid_reg <= bvalid_next;
      awready_reg <= ~aw_hold_next & ~bvalid_next;
      wready_reg <= ~w_hold_next & ~bvalid_next;
    end
  end

  // AXI4-Lite read channel: data one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `NCS_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      arready_reg <= ~rvalid_next;
      if (ar_take) begin
        rresp_reg <= `NCS_RESP_OKAY;
        case (s_axi_araddr)
          `NCS_OFF_CTRL: rdata_reg <= {30'h0, ctrl_reg};
          `NCS_OFF_CFG: rdata_reg <= {rate_kbps(rate_sel_reg), 1'b0, cfg_done_reg,
            id_err_reg, fw_reg, pair_mode_reg, rate_sel_reg, 1'b0, node_id_reg};
          `NCS_OFF_INPUT: rdata_reg <= {{(31 - NCH){1'b0}}, term_filt_reg,
            input_word_reg};
          `NCS_OFF_LAMP: rdata_reg <= {29'h0, term_lamp_reg, err_lamp_reg,
            run_lamp_reg};
          `NCS_OFF_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
          `NCS_OFF_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
          default: begin
            rdata_reg <= 32'h0;
            rresp_reg <= `NCS_RESP_DECERR;
          end
        endcase
      end
    end
  end

  // Output connections
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign input_word = input_word_reg;
  assign pair_out_word = pair_out_reg;
  assign node_id = node_id_reg;
  assign rate_sel = rate_sel_reg;
  assign pair_mode = pair_mode_reg;
  assign fw_update_mode = fw_reg;
  assign slave_enable = slave_en_reg;
  assign auto_start_req = auto_start_reg;
  assign cfg_done = cfg_done_reg;
  assign run_lamp = run_lamp_reg;
  assign err_lamp = err_lamp_reg;
  assign term_lamp = term_lamp_reg;
  assign input_lamp = input_lamp_reg;
  assign irq = irq_reg;

endmodule

// file: ncs_node_cfg_monitor.sv
// Checker for switch capture, input paths and automatic start request
`timescale 1ns/1ps
module ncs_node_cfg_monitor #(
  parameter NCH = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Switches, pins and core state
  input wire [3:0] id_tens_sw,
  input wire [3:0] id_units_sw,
  input wire [3:0] rate_sw,
  input wire [NCH-1:0] digital_input_channel,
  input wire [1:0] core_nmt_state,
  // Observed outputs
  input wire [NCH-1:0] input_word,
  input wire [NCH-1:0] pair_out_word,
  input wire [NCH-1:0] input_lamp,
  input wire [6:0] node_id,
  input wire [2:0] rate_sel,
  input wire pair_mode,
  input wire fw_update_mode,
  input wire slave_enable,
  input wire auto_start_req,
  input wire cfg_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Settled pins reach the core word, the lamps and the paired outputs
  a_input_word: assert property ($stable(digital_input_channel)[*8] |->
    input_word == digital_input_channel) else $error("input word differs from pins");
  a_lamp_raw: assert property ($stable(digital_input_channel)[*8] |->
    input_lamp == digital_input_channel || input_lamp == {NCH{1'b0}})
    else $error("input lamps differ from pins");
  a_pair_out: assert property (($stable(digital_input_channel) && $stable(pair_mode))[*8] |->
    pair_out_word == (pair_mode ? digital_input_channel : {NCH{1'b0}}))
    else $error("paired output word wrong");
  // Decoded configuration at the moment of capture, then held
  a_rate_mode: assert property ($rose(cfg_done) |->
    rate_sel == rate_sw[2:0] ##1 pair_mode == $past(rate_sw[3]))
    else $error("rate or mode wrong");
  a_fw_zero: assert property ($rose(cfg_done) |->
    fw_update_mode == (id_tens_sw == 4'h0 && id_units_sw == 4'h0)) else $error("update mode wrong");
  a_node_id: assert property ($rose(cfg_done) && id_tens_sw <= 4'h9 && id_units_sw <= 4'h9 |->
    node_id == {3'h0, id_tens_sw} * 7'h0A + {3'h0, id_units_sw}
    ##1 slave_enable == (node_id != 7'h00))
    else $error("node id decode wrong");
  a_cfg_held: assert property (cfg_done && $past(cfg_done) |->
    $stable(node_id) && $stable(rate_sel) && $stable(fw_update_mode)) else $error("config moved");
  a_auto_start: assert property (1'b1 |=>
    auto_start_req == $past(pair_mode && slave_enable && core_nmt_state != 2'h3))
    else $error("auto start request wrong");
  // Main scenarios
  c_pair: cover property ($rose(pair_mode));
  c_update: cover property ($rose(fw_update_mode));
  c_start: cover property (auto_start_req ##1 !auto_start_req);
endmodule

// file: ncs_core_model.sv
// Protocol core and paired output module stand-in
`timescale 1ns/1ps
module ncs_core_model #(
  parameter PAIR_ID = 1 // Odd id of the paired output module
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bench command of the network state
  input wire cmd_wr,
  input wire [1:0] cmd_state,
  // Block side
  input wire auto_start_req,
  input wire [15:0] pair_out_word,
  output reg [1:0] core_nmt_state,
  output reg [15:0] pair_do
);
  // State follows commands; a start request forces Operational
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_nmt_state <= 2'h0;
      pair_do <= 16'h0000;
    end else begin
      if (auto_start_req) begin
        core_nmt_state <= 2'h3;
      end else if (cmd_wr) begin
        core_nmt_state <= cmd_state;
      end
      pair_do <= pair_out_word; // Output of the same index follows
    end
  end
endmodule

// file: ncs_node_cfg_test.sv
// Self-checking bench for the node configuration and status block
`timescale 1ns/1ps
`include "ncs_node_cfg_defs.vh"
module ncs_node_cfg_test;
  typedef struct {logic [3:0] t; logic [3:0] u; logic [3:0] r; logic [6:0] id;} ncs_row_t;
  localparam int PH = 8;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0] s_axi_wstrb, id_tens_sw, id_units_sw, rate_sw;
  logic [15:0] digital_input_channel;
  logic term_enable_pin, core_err_warn, core_guard_fail, core_bus_off, cmd_wr;
  logic [1:0] cmd_state, resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, core_nmt_state;
  wire [31:0] s_axi_rdata;
  wire [15:0] input_word, pair_out_word, input_lamp, pair_do;
  wire [6:0] node_id;
  wire [2:0] rate_sel;
  wire pair_mode, fw_update_mode, slave_enable, auto_start_req, cfg_done;
  wire run_lamp, err_lamp, term_lamp, irq;
  int bad_count, n_tests, i;
  logic [15:0] kbps_tab [8] = '{16'h000A, 16'h0014, 16'h0032, 16'h007D,
    16'h00FA, 16'h01F4, 16'h0320, 16'h03E8};
  int run_tab [4] = '{0, PH, 3 * PH, 6 * PH};
  int err_tab [4] = '{0, PH, 2 * PH, 6 * PH};
  logic [2:0] err_sel [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  // Tens, units, rate code, expected id (7F marks a bad digit)
  ncs_row_t rows [16] = '{'{4'h3,4'h2,4'h0,7'h20}, '{4'h9,4'h9,4'h1,7'h63},
    '{4'h0,4'h0,4'h2,7'h00}, '{4'hA,4'h1,4'h3,7'h7F}, '{4'h1,4'h4,4'h4,7'h0E},
    '{4'h0,4'h1,4'h5,7'h01}, '{4'h5,4'h0,4'h6,7'h32}, '{4'h4,4'h2,4'h7,7'h2A},
    '{4'h0,4'h2,4'h8,7'h02}, '{4'h1,4'h0,4'h9,7'h0A}, '{4'h2,4'h3,4'hA,7'h17},
    '{4'h6,4'h1,4'hB,7'h3D}, '{4'h7,4'h7,4'hC,7'h4D}, '{4'h8,4'h8,4'hD,7'h58},
    '{4'h3,4'h3,4'hE,7'h21}, '{4'h0,4'h2,4'hF,7'h02}};
  ncs_node_cfg #(.PHASE_CYCLES(PH)) dut (.*);
  ncs_core_model model (.*);
  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", name, exp, seen);
    end
  endtask
  // Register write: address and data offered together, held until taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    while ((s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid) && t < 50) begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    check("write answer", t < 50, 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Register read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    while ((s_axi_arvalid || !s_axi_rvalid) && t < 50) begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    check("read answer", t < 50, 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Set switches, reset for three cycles, wait for the capture
  task automatic do_reset(input ncs_row_t w);
    @(posedge aclk);
    id_tens_sw <= w.t;
    id_units_sw <= w.u;
    rate_sw <= w.r;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) begin
      @(posedge aclk);
      if (cfg_done === 1'b1) break;
    end
    // Pair mode and slave enable follow the capture one cycle later
    repeat (2) @(posedge aclk);
  endtask
  // Lit cycles of a lamp over one full pattern period
  task automatic lamp_count(input int sel, input int exp);
    logic [31:0] c;
    c = 32'h0;
    repeat (4) @(posedge aclk);
    repeat (6 * PH) begin
      @(posedge aclk);
      c = c + (sel ? err_lamp : run_lamp);
    end
    check("lamp lit cycles", c, exp);
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #100000;
    bad_count++;
    complete_run;
  end
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {id_tens_sw, id_units_sw, rate_sw} = 12'h000;
    digital_input_channel = 16'h0000;
    {term_enable_pin, core_err_warn, core_guard_fail, core_bus_off, cmd_wr} = 5'h00;
    cmd_state = 2'h0;
    for (i = 0; i < 16; i++) begin
      do_reset(rows[i]);
      check("cfg_done", cfg_done, 1'b1);
      if (rows[i].id != 7'h7F) check("node_id", node_id, rows[i].id);
      check("slave_enable", slave_enable, rows[i].id != 7'h00 && rows[i].id != 7'h7F);
      check("fw_update_mode", fw_update_mode, rows[i].id == 7'h00);
      check("pair_mode", pair_mode, rows[i].r[3]);
      check("rate_sel", rate_sel, rows[i].r[2:0]);
      axi_rd(`NCS_OFF_CFG, rd, resp);
      check("kbps", rd[31:16], kbps_tab[rows[i].r[2:0]]);
    end
    // Last row: id 2 beside an odd partner id 1, pair mode
    axi_rd(`NCS_OFF_CTRL, rd, resp);
    check("ctrl reset", rd, 32'h3);
    axi_rd(`NCS_OFF_IRQ_MASK, rd, resp);
    check("mask reset", rd, 32'h0);
    check("nmt state", core_nmt_state, 2'h3);
    check("auto start", auto_start_req, 1'b0);
    digital_input_channel <= 16'hA5C3;
    id_tens_sw <= 4'h5;
    rate_sw <= 4'h0;
    repeat (10) @(posedge aclk);
    check("input_word", input_word, 16'hA5C3);
    check("input_lamp", input_lamp, 16'hA5C3);
    check("pair output", pair_do, 16'hA5C3);
    check("held id", node_id, 7'h02);
    check("held mode", pair_mode, 1'b1);
    check("partner id", node_id, model.PAIR_ID + 1);
    for (i = 0; i < 2; i++) begin
      term_enable_pin <= ~i[0];
      repeat (8) @(posedge aclk);
      check("term lamp", term_lamp, !i[0]);
    end
    // Pair mode off, then every network state and error level
    axi_wr(`NCS_OFF_CTRL, 32'h1, resp);
    for (i = 0; i < 4; i++) begin
      @(posedge aclk);
      cmd_state <= i[1:0];
      cmd_wr <= 1'b1;
      @(posedge aclk);
      cmd_wr <= 1'b0;
      lamp_count(0, run_tab[i]);
    end
    for (i = 0; i < 4; i++) begin
      @(posedge aclk);
      {core_bus_off, core_guard_fail, core_err_warn} <= err_sel[i];
      lamp_count(1, err_tab[i]);
    end
    axi_wr(`NCS_OFF_CTRL, 32'h0, resp);
    lamp_count(1, 0);
    // Interrupt raised, masked, unmasked and cleared; errors quiet before the clear
    core_bus_off <= 1'b0;
    axi_wr(`NCS_OFF_IRQ_STAT, 32'h7, resp);
    core_err_warn <= 1'b1;
    repeat (3) @(posedge aclk);
    check("masked irq", irq, 1'b0);
    axi_rd(`NCS_OFF_IRQ_STAT, rd, resp);
    check("irq status", rd, 32'h2);
    axi_wr(`NCS_OFF_IRQ_MASK, 32'h2, resp);
    repeat (2) @(posedge aclk);
    check("irq", irq, 1'b1);
    axi_wr(`NCS_OFF_IRQ_STAT, 32'h2, resp);
    repeat (2) @(posedge aclk);
    check("cleared irq", irq, 1'b0);
    // Lane 0 strobe low: the write leaves the mask alone
    s_axi_wstrb <= 4'h0;
    axi_wr(`NCS_OFF_IRQ_MASK, 32'h0, resp);
    s_axi_wstrb <= 4'hF;
    axi_rd(`NCS_OFF_IRQ_MASK, rd, resp);
    check("strobed mask", rd, 32'h2);
    // Unmapped address
    axi_rd(8'h18, rd, resp);
    check("unmapped read", {rd[29:0], resp}, {30'h0, `NCS_RESP_DECERR});
    axi_wr(8'h18, 32'h1, resp);
    check("unmapped write", resp, `NCS_RESP_DECERR);
    complete_run;
  end
endmodule
bind ncs_node_cfg ncs_node_cfg_monitor #(.NCH(NCH)) mon (.*);
